// file: design/aicr_pkg.sv
// Shared constants of the audio channel router: register map, field layout,
// reset values, mode encodings and the boost gain table.
// Assumes a 32-bit APB bus and samples delivered in the pclk domain.
package aicr_pkg;

	localparam logic [7:0] AICR_CTRL_OFS   = 8'h00;
	localparam logic [7:0] AICR_BOOST_OFS  = 8'h04;
	localparam logic [7:0] AICR_ISTAT_OFS  = 8'h08;
	localparam logic [7:0] AICR_IMASK_OFS  = 8'h0C;
	localparam logic [7:0] AICR_STATUS_OFS = 8'h10;

	localparam int AICR_RET_MODE_LSB = 0;
	localparam int AICR_O1_MODE_LSB  = 2;
	localparam int AICR_O2_MODE_LSB  = 4;
	localparam int AICR_O1_INV_BIT   = 6;
	localparam int AICR_O2_INV_BIT   = 7;
	localparam int AICR_MIRROR_BIT   = 8;
	localparam int AICR_AES_SEL_BIT  = 9;
	localparam int AICR_DIG_SRC_LSB  = 10;
	localparam int AICR_CTRL_W       = 12;
	localparam int AICR_O1_BOOST_LSB = 0;
	localparam int AICR_O2_BOOST_LSB = 8;
	localparam int AICR_IRQ_W        = 2;

	localparam logic [11:0] AICR_CTRL_RST  = 12'h0_001;
	localparam logic [4:0]  AICR_BOOST_RST = 5'h00;
	localparam logic [4:0]  AICR_BOOST_MAX = 5'h12;
	localparam logic [1:0]  AICR_IMASK_RST = 2'h0;

	// Return input shaping.
	localparam logic [1:0] AICR_RET_STEREO = 2'h0;
	localparam logic [1:0] AICR_RET_LEFT   = 2'h1;
	localparam logic [1:0] AICR_RET_SUM    = 2'h2;
	// First output pair shaping.
	localparam logic [1:0] AICR_O1_STEREO  = 2'h0;
	localparam logic [1:0] AICR_O1_SUM     = 2'h1;
	localparam logic [1:0] AICR_O1_COPY_LR = 2'h2;
	// Second output pair shaping.
	localparam logic [1:0] AICR_O2_LEFT    = 2'h0;
	localparam logic [1:0] AICR_O2_SUM     = 2'h1;
	localparam logic [1:0] AICR_O2_STEREO  = 2'h2;
	// Digital output source.
	localparam logic [1:0] AICR_DIG_OUT1   = 2'h0;
	localparam logic [1:0] AICR_DIG_OUT2   = 2'h1;
	localparam logic [1:0] AICR_DIG_RET    = 2'h2;
	localparam logic [1:0] AICR_DIG_MAIN   = 2'h3;

	localparam int AICR_GAIN_FRAC = 12;

	// Linear gain for whole decibel steps, unsigned with twelve fraction bits.
	function automatic logic [15:0] aicr_gain(input logic [4:0] db);
		case (db)
			5'h00: aicr_gain = 16'h1000;
			5'h01: aicr_gain = 16'h11F4;
			5'h02: aicr_gain = 16'h1425;
			5'h03: aicr_gain = 16'h169A;
			5'h04: aicr_gain = 16'h195C;
			5'h05: aicr_gain = 16'h1C74;
			5'h06: aicr_gain = 16'h1FED;
			5'h07: aicr_gain = 16'h23D2;
			5'h08: aicr_gain = 16'h2831;
			5'h09: aicr_gain = 16'h2D18;
			5'h0A: aicr_gain = 16'h3299;
			5'h0B: aicr_gain = 16'h38C5;
			5'h0C: aicr_gain = 16'h3FB2;
			5'h0D: aicr_gain = 16'h4778;
			5'h0E: aicr_gain = 16'h5031;
			5'h0F: aicr_gain = 16'h59FA;
			5'h10: aicr_gain = 16'h64F4;
			5'h11: aicr_gain = 16'h7145;
			default: aicr_gain = 16'h7F17;
		endcase
	endfunction : aicr_gain

endpackage : aicr_pkg

// file: design/aicr_router.sv
// Stereo sample router: return input shaping, two output pairs with mode,
// boost and polarity, mirror of output one into output two, digital outputs.
// Assumes samples arrive from logic on pclk, one frame per frame_strobe pulse.
//
// Functional notes
// - return input stereo, left only or summed
// - output one stereo, sum or left copied
// - output one boost zero to eighteen dB
// - output one boost also reaches digital, USB
// - clip indicator lights when boosted output clips
// - output one polarity normal or negated
// - inversion always negates both channels together
// - output two mode after effects send mixer
// - output two mode applies to mirrored signal
// - output two has independent boost
// - output two has independent polarity
// - mirror feeds output two from output one
// - mirror overrides other output two sources
// - S/PDIF or AES enabled, never both
// - one selected source feeds both digital outputs
// - mirror taps before output one boost and polarity
// - settings act without any store step
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/100ps

module aicr_router
	import aicr_pkg::*;
#(
	parameter int SAMPLE_W = 24
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic [31:0]              prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                frame_strobe,
	input  wire logic [SAMPLE_W-1:0] main_in_l,
	input  wire logic [SAMPLE_W-1:0] main_in_r,
	input  wire logic [SAMPLE_W-1:0] effects_return_input_l,
	input  wire logic [SAMPLE_W-1:0] effects_return_input_r,
	input  wire logic [SAMPLE_W-1:0] grid_out_l,
	input  wire logic [SAMPLE_W-1:0] grid_out_r,
	input  wire logic [SAMPLE_W-1:0] effects_send_block_l,
	input  wire logic [SAMPLE_W-1:0] effects_send_block_r,
	output logic                     sample_valid,
	output logic [SAMPLE_W-1:0]      ret_out_l,
	output logic [SAMPLE_W-1:0]      ret_out_r,
	output logic [SAMPLE_W-1:0]      out1_l,
	output logic [SAMPLE_W-1:0]      out1_r,
	output logic [SAMPLE_W-1:0]      out2_l,
	output logic [SAMPLE_W-1:0]      out2_r,
	output logic [SAMPLE_W-1:0]      usb_out_l,
	output logic [SAMPLE_W-1:0]      usb_out_r,
	output logic [SAMPLE_W-1:0]      dig_out_l,
	output logic [SAMPLE_W-1:0]      dig_out_r,
	output logic                     spdif_enable,
	output logic                     aes_enable,
	output logic                     main_out_clip_indicator,
	output logic                     irq
);

	localparam int W = SAMPLE_W;
	localparam logic [W-1:0] SMAX = {1'b0, {(W-1){1'b1}}};
	localparam logic [W-1:0] SMIN = {1'b1, {(W-1){1'b0}}};

	// Halved sum: one extra bit of headroom, then drop the lsb.
	function automatic logic [W-1:0] half_sum(input logic [W-1:0] a, input logic [W-1:0] b);
		logic [W:0] s;
		s = {a[W-1], a} + {b[W-1], b};
		half_sum = s[W:1];
	endfunction : half_sum

	// Negation saturates the most negative code instead of wrapping to itself.
	function automatic logic [W-1:0] negate(input logic [W-1:0] a);
		negate = (a == SMIN) ? SMAX : W'(-a);
	endfunction : negate

	// Returns {clip, sample}: gain applied, result saturated to the word.
	function automatic logic [W:0] amp(input logic [W-1:0] a, input logic [4:0] db);
		logic signed [W+16:0] p;
		logic [W+4:0]         q;
		p = $signed(a) * $signed({1'b0, aicr_gain(db)});
		q = p[W+16:AICR_GAIN_FRAC];
		if ((&q[W+4:W-1]) || !(|q[W+4:W-1]))
			amp = {1'b0, q[W-1:0]};
		else
			amp = {1'b1, q[W+4] ? SMIN : SMAX};
	endfunction : amp

	logic [AICR_CTRL_W-1:0] ctrl_ff;
	logic [4:0]             boost1_ff;
	logic [4:0]             boost2_ff;
	logic [AICR_IRQ_W-1:0]  istat_ff;
	logic [AICR_IRQ_W-1:0]  imask_ff;
	logic [31:0]            prdata_ff;
	logic                   clip2_ff;

	logic [1:0]   ret_mode;
	logic [1:0]   o1_mode;
	logic [1:0]   o2_mode;
	logic [1:0]   dig_src;
	logic         o1_inv;
	logic         o2_inv;
	logic         mirror_main_to_second;
	logic         aes_sel;

	assign ret_mode = ctrl_ff[AICR_RET_MODE_LSB +: 2];
	assign o1_mode  = ctrl_ff[AICR_O1_MODE_LSB +: 2];
	assign o2_mode  = ctrl_ff[AICR_O2_MODE_LSB +: 2];
	assign dig_src  = ctrl_ff[AICR_DIG_SRC_LSB +: 2];
	assign o1_inv   = ctrl_ff[AICR_O1_INV_BIT];
	assign o2_inv   = ctrl_ff[AICR_O2_INV_BIT];
	assign aes_sel  = ctrl_ff[AICR_AES_SEL_BIT];
	assign mirror_main_to_second = ctrl_ff[AICR_MIRROR_BIT];

	logic         wr_en;
	logic         rd_en;
	logic         addr_hit;

	assign addr_hit = (paddr == AICR_CTRL_OFS) || (paddr == AICR_BOOST_OFS) ||
	                  (paddr == AICR_ISTAT_OFS) || (paddr == AICR_IMASK_OFS) ||
	                  (paddr == AICR_STATUS_OFS);
	assign wr_en   = psel && penable && pwrite && addr_hit;
	assign rd_en   = psel && penable && !pwrite && addr_hit;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !addr_hit;
	assign prdata  = prdata_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff   <= AICR_CTRL_RST;
			boost1_ff <= AICR_BOOST_RST;
			boost2_ff <= AICR_BOOST_RST;
			imask_ff  <= AICR_IMASK_RST;
		end else if (wr_en) begin
			case (paddr)
				AICR_CTRL_OFS: ctrl_ff <= pwdata[AICR_CTRL_W-1:0];
				AICR_BOOST_OFS: begin
					boost1_ff <= (pwdata[AICR_O1_BOOST_LSB +: 5] > AICR_BOOST_MAX) ?
					             AICR_BOOST_MAX : pwdata[AICR_O1_BOOST_LSB +: 5];
					boost2_ff <= (pwdata[AICR_O2_BOOST_LSB +: 5] > AICR_BOOST_MAX) ?
					             AICR_BOOST_MAX : pwdata[AICR_O2_BOOST_LSB +: 5];
				end
				AICR_IMASK_OFS: imask_ff <= pwdata[AICR_IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// Read data is latched in the setup cycle, so it is stable in the access cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				AICR_CTRL_OFS:   prdata_ff <= 32'(ctrl_ff);
				AICR_BOOST_OFS:  prdata_ff <= 32'({boost2_ff, 3'h0, boost1_ff});
				AICR_ISTAT_OFS:  prdata_ff <= 32'(istat_ff);
				AICR_IMASK_OFS:  prdata_ff <= 32'(imask_ff);
				AICR_STATUS_OFS: prdata_ff <= 32'({aes_enable, spdif_enable, clip2_ff,
				                                   main_out_clip_indicator});
				default:         prdata_ff <= 32'h0000_0000;
			endcase
		end
	end

	logic [W-1:0] r_l, r_r, m1_l, m1_r, s2_l, s2_r, m2_l, m2_r;
	logic [W-1:0] o1_l, o1_r, o2_l, o2_r, d_l, d_r;
	logic [W:0]   b1_l, b1_r, b2_l, b2_r;
	logic         clip1, clip2;

	// The whole frame is computed in one cycle from one set of settings.
	always_comb begin
		case (ret_mode)
			AICR_RET_LEFT: {r_l, r_r} = {2{effects_return_input_l}};
			AICR_RET_SUM:  {r_l, r_r} = {2{half_sum(effects_return_input_l,
			                                         effects_return_input_r)}};
			default:       {r_l, r_r} = {effects_return_input_l, effects_return_input_r};
		endcase
		case (o1_mode)
			AICR_O1_SUM:     {m1_l, m1_r} = {2{half_sum(grid_out_l, grid_out_r)}};
			AICR_O1_COPY_LR: {m1_l, m1_r} = {2{grid_out_l}};
			default:         {m1_l, m1_r} = {grid_out_l, grid_out_r};
		endcase
		b1_l  = amp(m1_l, boost1_ff);
		b1_r  = amp(m1_r, boost1_ff);
		clip1 = b1_l[W] || b1_r[W];
		o1_l = o1_inv ? negate(b1_l[W-1:0]) : b1_l[W-1:0];
		o1_r = o1_inv ? negate(b1_r[W-1:0]) : b1_r[W-1:0];
		s2_l = mirror_main_to_second ? m1_l : effects_send_block_l;
		s2_r = mirror_main_to_second ? m1_r : effects_send_block_r;
		case (o2_mode)
			AICR_O2_LEFT: begin
				m2_l = s2_l;
				m2_r = s2_l;
			end
			AICR_O2_SUM: begin
				m2_l = half_sum(s2_l, s2_r);
				m2_r = m2_l;
			end
			default: begin
				m2_l = s2_l;
				m2_r = s2_r;
			end
		endcase
		b2_l  = amp(m2_l, boost2_ff);
		b2_r  = amp(m2_r, boost2_ff);
		clip2 = b2_l[W] || b2_r[W];
		o2_l = o2_inv ? negate(b2_l[W-1:0]) : b2_l[W-1:0];
		o2_r = o2_inv ? negate(b2_r[W-1:0]) : b2_r[W-1:0];
		case (dig_src)
			AICR_DIG_OUT1: {d_l, d_r} = {o1_l, o1_r};
			AICR_DIG_OUT2: {d_l, d_r} = {o2_l, o2_r};
			AICR_DIG_RET:  {d_l, d_r} = {r_l, r_r};
			default:       {d_l, d_r} = {main_in_l, main_in_r};
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ret_out_l <= '0;
			ret_out_r <= '0;
			out1_l    <= '0;
			out1_r    <= '0;
			out2_l    <= '0;
			out2_r    <= '0;
			usb_out_l <= '0;
			usb_out_r <= '0;
			dig_out_l <= '0;
			dig_out_r <= '0;
		end else if (frame_strobe) begin
			ret_out_l <= r_l;
			ret_out_r <= r_r;
			out1_l    <= o1_l;
			out1_r    <= o1_r;
			out2_l    <= o2_l;
			out2_r    <= o2_r;
			usb_out_l <= o1_l;
			usb_out_r <= o1_r;
			dig_out_l <= d_l;
			dig_out_r <= d_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			main_out_clip_indicator <= 1'b0;
			clip2_ff                <= 1'b0;
			sample_valid            <= 1'b0;
		end else begin
			sample_valid <= frame_strobe;
			if (frame_strobe) begin
				main_out_clip_indicator <= clip1;
				clip2_ff                <= clip2;
			end
		end
	end

	// A clip in the same cycle as the clearing read stays recorded.
	// Only the bits that the read returned are cleared, so a clip that lands
	// between the setup and the access edge is not lost.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			istat_ff <= '0;
		else
			istat_ff <= (istat_ff & ~((rd_en && paddr == AICR_ISTAT_OFS) ?
			                          prdata_ff[AICR_IRQ_W-1:0] : '0)) |
			            {frame_strobe && clip2, frame_strobe && clip1};
	end

	assign irq = |(istat_ff & imask_ff);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			spdif_enable <= 1'b1;
			aes_enable   <= 1'b0;
		end else begin
			spdif_enable <= !aes_sel;
			aes_enable   <= aes_sel;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence frame_s;
		frame_strobe;
	endsequence

	sequence plain_out1_s;
		frame_s ##0 (boost1_ff == AICR_BOOST_RST) && (o1_mode == AICR_O1_STEREO);
	endsequence

	ret_sum_a: assert property (frame_s ##0 ret_mode == AICR_RET_SUM |=>
		ret_out_l == half_sum($past(effects_return_input_l), $past(effects_return_input_r))
		&& ret_out_r == ret_out_l)
		else $error("Return sum is not the halved sum on both channels.");

	ret_left_a: assert property (frame_s ##0 ret_mode == AICR_RET_LEFT |=>
		ret_out_l == $past(effects_return_input_l) && ret_out_r == ret_out_l)
		else $error("Return left-only mode does not copy left.");

	out1_copy_a: assert property (frame_s ##0 o1_mode == AICR_O1_COPY_LR |=>
		out1_r == out1_l)
		else $error("Output one copy mode gives different channels.");

	out1_pass_a: assert property (plain_out1_s ##0 !o1_inv |=>
		out1_l == $past(grid_out_l) && out1_r == $past(grid_out_r))
		else $error("Output one normal polarity alters samples.");

	out1_invert_a: assert property (plain_out1_s ##0 o1_inv |=>
		out1_l == negate($past(grid_out_l)) && out1_r == negate($past(grid_out_r)))
		else $error("Output one inversion misses a channel.");

	clip_flag_a: assert property (frame_s ##0 clip1 |=>
		main_out_clip_indicator ##1 (istat_ff[0] || $past(rd_en)))
		else $error("Output one clip not flagged.");

	mirror_src_a: assert property (frame_s ##0 mirror_main_to_second && !o2_inv &&
		o2_mode == AICR_O2_STEREO && boost2_ff == AICR_BOOST_RST |=>
		out2_l == $past(m1_l) && out2_r == $past(m1_r))
		else $error("Output two does not follow the mirrored output one.");

	dig_excl_a: assert property (spdif_enable != aes_enable)
		else $error("Both digital interfaces enabled.");

	dig_same_a: assert property (frame_s ##0 dig_src == AICR_DIG_OUT1 |=>
		dig_out_l == out1_l && dig_out_r == out1_r && usb_out_l == out1_l)
		else $error("Digital outputs do not carry output one.");

	irq_level_a: assert property (frame_s ##0 clip1 && imask_ff[0] && !wr_en |=> irq)
		else $error("Interrupt low after an unmasked output one clip.");

	ctrl_write_a: assert property (wr_en && paddr == AICR_CTRL_OFS |=>
		ctrl_ff == AICR_CTRL_W'($past(pwdata)))
		else $error("Control write did not take effect at once.");

endmodule : aicr_router

// file: verif/aicr_conv_model.sv
// Sink that stands for the converters and the digital audio ports.
// Assumes the router presents each frame with a one-cycle sample_valid.
`timescale 1ns/100ps

module aicr_conv_model (
	input  wire logic        pclk,
	input  wire logic        sample_valid,
	input  wire logic [23:0] dig_l,
	input  wire logic [23:0] dig_r,
	input  wire logic        spdif_enable,
	input  wire logic        aes_enable,
	output logic [23:0]      got_dig_l,
	output logic [23:0]      got_dig_r,
	output logic             port_clash
);
	// Only valid frames are taken, so a stale output never passes for a new one.
	always_ff @(posedge pclk) begin
		if (sample_valid === 1'b1) begin
			got_dig_l <= dig_l;
			got_dig_r <= dig_r;
		end
	end

	assign port_clash = (spdif_enable !== ~aes_enable);
endmodule : aicr_conv_model

// file: verif/aicr_router_bench.sv
// Self-checking bench of the channel router: APB set-up, frames, clip interrupt.
// Assumes zero-wait APB and one frame per frame_strobe pulse.
`timescale 1ns/100ps

module aicr_router_bench import aicr_pkg::*;;
	typedef struct packed {
		logic [11:0] ctrl;
		logic [15:0] boost;
		logic [23:0] o1l, o1r, o2l, o2r, rl, rr, dl, dr;
	} aicr_row_t;

	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, er, frame_strobe = 1'b0;
	logic [23:0] grid_l = 24'h00_0100;
	logic [23:0] grid_r = 24'h00_0300;
	logic [23:0] send_l = 24'h00_0010;
	logic [23:0] send_r = 24'h00_0030;
	logic [23:0] ret_out_l, ret_out_r, out1_l, out1_r, out2_l, out2_r;
	logic [23:0] usb_out_l, usb_out_r, dig_out_l, dig_out_r, got_dig_l, got_dig_r;
	logic        sample_valid, spdif_enable, aes_enable, clip, irq, port_clash;
	aicr_row_t   rows [8];
	int          error_cnt = 0;
	int          n_compared = 0;

	always #2.5 pclk = ~pclk;

	aicr_router #(.SAMPLE_W(24)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .frame_strobe(frame_strobe),
		.main_in_l(24'h00_0444), .main_in_r(24'h00_0555),
		.effects_return_input_l(24'h00_0002), .effects_return_input_r(24'h00_0006),
		.grid_out_l(grid_l), .grid_out_r(grid_r),
		.effects_send_block_l(send_l), .effects_send_block_r(send_r),
		.sample_valid(sample_valid), .ret_out_l(ret_out_l), .ret_out_r(ret_out_r),
		.out1_l(out1_l), .out1_r(out1_r), .out2_l(out2_l), .out2_r(out2_r),
		.usb_out_l(usb_out_l), .usb_out_r(usb_out_r), .dig_out_l(dig_out_l),
		.dig_out_r(dig_out_r), .spdif_enable(spdif_enable), .aes_enable(aes_enable),
		.main_out_clip_indicator(clip), .irq(irq)
	);

	aicr_conv_model u_conv (
		.pclk(pclk), .sample_valid(sample_valid), .dig_l(dig_out_l), .dig_r(dig_out_r),
		.spdif_enable(spdif_enable), .aes_enable(aes_enable), .got_dig_l(got_dig_l),
		.got_dig_r(got_dig_r), .port_clash(port_clash)
	);

	task automatic stop_test;
		$display("Compared %0d, errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic frame(input logic [23:0] gl);
		@(posedge pclk);
		grid_l <= gl;
		frame_strobe <= 1'b1;
		@(posedge pclk);
		frame_strobe <= 1'b0;
		#1;
	endtask : frame

	initial begin
		#100000;
		error_cnt++;
		stop_test();
	end

	initial begin
		rows[0] = {12'h00F, 16'h0000, 24'h00_0100, 24'h00_0300, 24'h00_0010, 24'h00_0010,
			24'h00_0002, 24'h00_0006, 24'h00_0100, 24'h00_0300};
		rows[1] = {12'h415, 16'h0000, 24'h00_0200, 24'h00_0200, 24'h00_0020, 24'h00_0020,
			24'h00_0002, 24'h00_0002, 24'h00_0020, 24'h00_0020};
		rows[2] = {12'hA2A, 16'h0000, 24'h00_0100, 24'h00_0100, 24'h00_0010, 24'h00_0030,
			24'h00_0004, 24'h00_0004, 24'h00_0004, 24'h00_0004};
		rows[3] = {12'hCE0, 16'h0000, 24'hFF_FF00, 24'hFF_FD00, 24'hFF_FFF0, 24'hFF_FFD0,
			24'h00_0002, 24'h00_0006, 24'h00_0444, 24'h00_0555};
		rows[4] = {12'h000, 16'h0006, 24'h00_01FE, 24'h00_05FC, 24'h00_0010, 24'h00_0010,
			24'h00_0002, 24'h00_0006, 24'h00_01FE, 24'h00_05FC};
		rows[5] = {12'h560, 16'h0606, 24'hFF_FE02, 24'hFF_FA04, 24'h00_01FE, 24'h00_05FC,
			24'h00_0002, 24'h00_0006, 24'h00_01FE, 24'h00_05FC};
		rows[6] = {12'h110, 16'h0000, 24'h00_0100, 24'h00_0300, 24'h00_0200, 24'h00_0200,
			24'h00_0002, 24'h00_0006, 24'h00_0100, 24'h00_0300};
		rows[7] = {12'h120, 16'h0000, 24'h00_0100, 24'h00_0300, 24'h00_0100, 24'h00_0300,
			24'h00_0002, 24'h00_0006, 24'h00_0100, 24'h00_0300};
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			apb(1'b1, AICR_CTRL_OFS, {20'h0_0000, rows[i].ctrl});
			apb(1'b1, AICR_BOOST_OFS, {16'h0000, rows[i].boost});
			frame(24'h00_0100);
			chk(sample_valid, 32'h1);
			chk(out1_l, rows[i].o1l);
			chk(out1_r, rows[i].o1r);
			chk(usb_out_r, rows[i].o1r);
			chk(usb_out_l, rows[i].o1l);
			chk(out2_l, rows[i].o2l);
			chk(out2_r, rows[i].o2r);
			chk(ret_out_l, rows[i].rl);
			chk(ret_out_r, rows[i].rr);
			chk(dig_out_l, rows[i].dl);
			chk(aes_enable, rows[i].ctrl[9]);
			@(posedge pclk);
			#1;
			chk(got_dig_r, rows[i].dr);
			chk(port_clash, 32'h0);
		end
		apb(1'b0, 8'h20, 32'h0000_0000);
		chk({er, rd[30:0]}, 32'h8000_0000);
		send_l <= 24'h00_0777;
		send_r <= 24'h00_0999;
		grid_r <= 24'h00_0100;
		frame(24'h00_0300);
		chk(out2_l, 24'h00_0300);
		chk(out2_r, 24'h00_0100);
		apb(1'b1, AICR_BOOST_OFS, 32'h0000_001F);
		apb(1'b0, AICR_BOOST_OFS, 32'h0000_0000);
		chk(rd, 32'h0000_0012);
		apb(1'b1, AICR_CTRL_OFS, 32'h0000_0000);
		apb(1'b1, AICR_IMASK_OFS, 32'h0000_0001);
		frame(24'h7F_FFFF);
		chk({clip, irq, out1_l}, {2'b11, 24'h7F_FFFF});
		frame(24'h00_0100);
		chk({clip, irq, out1_l}, {2'b01, 24'h00_07F1});
		apb(1'b0, AICR_ISTAT_OFS, 32'h0000_0000);
		#1;
		chk({rd[0], irq}, 32'h2);
		apb(1'b1, AICR_IMASK_OFS, 32'h0000_0000);
		frame(24'h7F_FFFF);
		chk({clip, irq}, 32'h2);
		@(posedge pclk);
		presetn <= 1'b0;
		#1;
		chk({out1_l, clip, irq, aes_enable, spdif_enable, pready}, 32'h3);
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, AICR_CTRL_OFS, 32'h0000_0000);
		chk(rd, 32'h0000_0001);
		stop_test();
	end
endmodule : aicr_router_bench
